// ### verilog/vectored_interrupt_controller.sv
// Vectored interrupt controller: flags, enables, priorities, proximity timer.
// Assumes an AXI4-Lite master and a core that pulses irq_ack on service.
// Summary of operation
// RULE1 - Key 0x4E write raises software NMI
// RULE2 - Control bit 12 selects multi-vector mode
// RULE3 - Threshold zero keeps proximity timer off
// RULE4 - Priority at or below threshold starts timer
// RULE5 - Polarity bit picks rising or falling edge
// RULE6 - Each level maps to shadow set 0-7
// RULE7 - Reserved shadow codes fall back to set 0
// RULE8 - Shadow fields ignored in single vector mode
// RULE9 - Single vector shadow bit enables shadow set
// RULE10 - Status reports level of last presented request
// RULE11 - Status reports last serviced request number
// RULE12 - Trigger loads reload value into timer
// RULE13 - Requests set flags; flags stay writable
// RULE14 - Unimplemented bits read zero, ignore writes
// RULE15 - Enable bit gates request toward core
// RULE16 - Priority zero disables the source
// RULE17 - Timer holds qualifying requests until expiry
// RULE18 - Highest priority, subpriority, lowest number wins
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "vic_defines.svh"
module vectored_interrupt_controller (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // AXI4-Lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Interrupt sources
    input  wire logic [31:0] src_req,
    input  wire logic [4:0]  ext_irq,
    // Core side
    input  wire logic        irq_ack,
    output logic             irq_req,
    output logic [7:0]       irq_num,
    output logic [2:0]       irq_level,
    output logic             irq_shadow_en,
    output logic [2:0]       irq_shadow_set,
    output logic             nmi_pulse
);
    // ****************************************
    // Functions
    // ****************************************
    // Byte strobes to bit mask
    function automatic logic [31:0] wmask(input logic [3:0] s);
        wmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : wmask

    // Strobed merge, unimplemented bits forced low
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s, input logic [31:0] impl);
        merge = ((o & ~wmask(s)) | (n & wmask(s))) & impl;
    endfunction : merge

    // ****************************************
    // State
    // ****************************************
    logic [31:0] ctrl_q, shadow_q, reload_q, flag_q, en_q, cnt_q, pend_prev_q;
    logic [31:0] prio_q [8];
    logic [7:0]  aw_addr_q, last_srv_q, rd_idx;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        aw_full_q, w_full_q, global_nmi_status_q;
    logic [2:0]  requested_priority_level_q;
    logic [4:0]  ext_prev_q;
    vic_pkg::prox_state_e state_q, state_d;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Address and data are held separately so they may arrive in any order
    wire aw_take  = awvalid & awready;
    wire w_take   = wvalid & wready;
    wire do_wr    = aw_full_q & w_full_q & ~bvalid;
    wire aw_full_d = ~do_wr & (aw_full_q | aw_take);
    wire w_full_d  = ~do_wr & (w_full_q | w_take);
    wire ar_take  = arvalid & arready;
    wire rvalid_d = ar_take | (rvalid & ~rready);

    // Address decode
    wire wr_prio  = aw_addr_q[7:5] == 3'b001;
    wire wr_hit   = wr_prio || aw_addr_q <= `OFS_NMI && aw_addr_q[1:0] == 2'b00;
    wire wr_ctrl  = do_wr && aw_addr_q == `OFS_CTRL;
    wire wr_sh    = do_wr && aw_addr_q == `OFS_SHADOW;
    wire wr_rel   = do_wr && aw_addr_q == `OFS_RELOAD;
    wire wr_flag  = do_wr && aw_addr_q == `OFS_FLAG;
    wire wr_en    = do_wr && aw_addr_q == `OFS_EN;
    wire wr_nmi   = do_wr && aw_addr_q == `OFS_NMI && w_strb_q[0] && w_data_q[0];
    assign rd_idx = araddr;
    wire rd_prio  = rd_idx[7:5] == 3'b001;
    wire rd_hit   = rd_prio || rd_idx <= `OFS_NMI && rd_idx[1:0] == 2'b00;

    // Read data selection
    wire [31:0] stat_word = {21'd0, requested_priority_level_q, last_srv_q};
    wire [31:0] rd_word =
        rd_prio                  ? prio_q[rd_idx[4:2]] :
        rd_idx == `OFS_CTRL      ? ctrl_q   :
        rd_idx == `OFS_SHADOW    ? shadow_q :
        rd_idx == `OFS_STAT      ? stat_word :
        rd_idx == `OFS_RELOAD    ? reload_q :
        rd_idx == `OFS_FLAG      ? flag_q   :
        rd_idx == `OFS_EN        ? en_q     :
        rd_idx == `OFS_NMI       ? {31'd0, global_nmi_status_q} : `RST_WORD;

    // Handshake registers; ready falls as soon as a slot is held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            arready   <= 1'b0;
            bvalid    <= 1'b0;
            rvalid    <= 1'b0;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready   <= ~aw_full_d;
            wready    <= ~w_full_d;
            arready   <= ~rvalid_d;
            bvalid    <= do_wr | (bvalid & ~bready);
            rvalid    <= rvalid_d;
        end
    end

    // Payload capture and responses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr_q <= 8'h00;
            w_data_q  <= `RST_WORD;
            w_strb_q  <= 4'h0;
            bresp     <= `RESP_OKAY;
            rresp     <= `RESP_OKAY;
            rdata     <= `RST_WORD;
        end
        else
        begin
            if (aw_take) aw_addr_q <= awaddr;
            if (w_take) w_data_q <= wdata;
            if (w_take) w_strb_q <= wstrb;
            if (do_wr) bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (ar_take) rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (ar_take) rdata <= rd_word;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    wire       vector_config_bit = ctrl_q[`VECTOR_CONFIG_BIT_BIT];
    wire [2:0] proximity_priority_threshold  = ctrl_q[`TPC_LSB +: 3];
    wire       key_hit = wr_ctrl && w_strb_q[3] && w_data_q[`KEY_LSB +: 8] == `KEY_VALUE;

    // Writable words; masks keep unimplemented bits at zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q   <= `RST_WORD;
            shadow_q <= `RST_WORD;
            reload_q <= `RST_WORD;
            en_q     <= `RST_WORD;
            for (int i = 0; i < 8; i++) prio_q[i] <= `RST_WORD;
        end
        else
        begin
            if (wr_ctrl) ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q, `CTRL_MASK); // RULE14
            if (wr_sh) shadow_q <= merge(shadow_q, w_data_q, w_strb_q, `SHADOW_MASK); // RULE14
            if (wr_rel) reload_q <= merge(reload_q, w_data_q, w_strb_q, 32'hFFFF_FFFF);
            if (wr_en) en_q <= merge(en_q, w_data_q, w_strb_q, 32'hFFFF_FFFF);
            if (do_wr && wr_prio)
                prio_q[aw_addr_q[4:2]] <= merge(prio_q[aw_addr_q[4:2]], w_data_q, w_strb_q, `PRIO_MASK);
        end
    end

    // ****************************************
    // Request flags and NMI
    // ****************************************
    // Edge select per external input
    wire [4:0]  ext_rise = ext_irq & ~ext_prev_q;
    wire [4:0]  ext_fall = ~ext_irq & ext_prev_q;
    wire [4:0]  ext_ev   = (ctrl_q[4:0] & ext_rise) | (~ctrl_q[4:0] & ext_fall); // RULE5
    wire [31:0] set_ev   = src_req | {27'd0, ext_ev};
    wire [31:0] flag_base = wr_flag ? merge(flag_q, w_data_q, w_strb_q, 32'hFFFF_FFFF) : flag_q;

    // New events win over a software clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flag_q     <= `RST_WORD;
            ext_prev_q <= 5'h00;
            global_nmi_status_q     <= 1'b0;
            nmi_pulse  <= 1'b0;
        end
        else
        begin
            flag_q     <= flag_base | set_ev; // RULE13
            ext_prev_q <= ext_irq;
            global_nmi_status_q     <= key_hit | (global_nmi_status_q & ~wr_nmi); // RULE1
            nmi_pulse  <= key_hit; // RULE1
        end
    end

    // ****************************************
    // Arbitration and proximity holdback
    // ****************************************
    logic [31:0] pend, qual, cand;
    logic [4:0]  win_idx;
    logic [4:0]  win_key;
    logic        win_ok;
    logic [2:0]  ip;
    logic [2:0]  ip_t;

    // Threshold test kept apart from the scan, so the trigger feeds no loop
    always_comb
    begin
        pend = flag_q & en_q; // RULE15
        qual = 32'd0;
        ip_t = 3'd0;
        for (int i = 0; i < 32; i++)
        begin
            ip_t    = prio_q[i / 4][8 * (i % 4) + 2 +: 3];
            qual[i] = ip_t != 3'd0 && ip_t <= proximity_priority_threshold; // RULE4
        end
    end

    // Trigger on a newly pending qualifying source
    wire trig = proximity_priority_threshold != 3'd0 && |(pend & ~pend_prev_q & qual); // RULE3 RULE4
    // Hold starts in the trigger cycle itself, else one request leaks early
    wire hold_all = state_q == vic_pkg::PROX_RUN || trig; // RULE17

    // Ascending scan with strict compare keeps the lowest number on ties
    always_comb
    begin
        cand    = 32'd0;
        win_idx = 5'd0;
        win_key = 5'd0;
        win_ok  = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            ip = prio_q[i / 4][8 * (i % 4) + 2 +: 3];
            cand[i] = pend[i] && ip != 3'd0 && !(hold_all && qual[i]); // RULE16 RULE17
            if (cand[i] && {ip, prio_q[i / 4][8 * (i % 4) +: 2]} > win_key) // RULE18
            begin
                win_key = {ip, prio_q[i / 4][8 * (i % 4) +: 2]};
                win_idx = 5'(i);
                win_ok  = 1'b1;
            end
        end
    end

    // Timer state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            vic_pkg::PROX_IDLE: if (trig) state_d = vic_pkg::PROX_RUN;
            vic_pkg::PROX_RUN:  if (cnt_q == 32'd0 || proximity_priority_threshold == 3'd0) state_d = vic_pkg::PROX_IDLE; // RULE3
            default:            state_d = vic_pkg::PROX_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q     <= vic_pkg::PROX_IDLE;
            cnt_q       <= `RST_WORD;
            pend_prev_q <= `RST_WORD;
        end
        else
        begin
            state_q     <= state_d;
            pend_prev_q <= pend;
            if (state_q == vic_pkg::PROX_IDLE && trig) cnt_q <= reload_q; // RULE12
            else if (state_q == vic_pkg::PROX_RUN && cnt_q != 32'd0) cnt_q <= cnt_q - 32'd1; // RULE17
        end
    end

    // ****************************************
    // Core outputs and status
    // ****************************************
    wire [2:0] win_lvl = win_key[4:2];
    wire [3:0] ss_fld  = shadow_q[4 * win_lvl +: 4];
    wire       sh_en_d = vector_config_bit ? 1'b1 : shadow_q[0]; // RULE2 RULE9
    wire [2:0] sh_set_d = (vector_config_bit && !ss_fld[3]) ? ss_fld[2:0] : 3'd0; // RULE6 RULE7 RULE8

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_req        <= 1'b0;
            irq_num        <= 8'h00;
            irq_level      <= 3'd0;
            irq_shadow_en  <= 1'b0;
            irq_shadow_set <= 3'd0;
            requested_priority_level_q        <= 3'd0;
            last_srv_q     <= 8'h00;
        end
        else
        begin
            irq_req        <= win_ok;
            irq_num        <= {3'd0, win_idx};
            irq_level      <= win_lvl;
            irq_shadow_en  <= win_ok & sh_en_d;
            irq_shadow_set <= sh_set_d;
            if (win_ok) requested_priority_level_q <= win_lvl; // RULE10
            if (irq_ack && irq_req) last_srv_q <= irq_num; // RULE11
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence key_write_s; key_hit; endsequence
    sequence nmi_seen_s; nmi_pulse && global_nmi_status_q; endsequence
    nmi_key_a: assert property (key_write_s |=> nmi_seen_s) else $error("nmi key missed"); // RULE1
    prox_off_a: assert property (proximity_priority_threshold == 3'd0 |=> state_q == vic_pkg::PROX_IDLE) else $error("timer on"); // RULE3
    reload_load_a: assert property (state_q == vic_pkg::PROX_IDLE && trig |=> cnt_q == $past(reload_q))
        else $error("reload not loaded"); // RULE12
    flag_set_a: assert property (1'b1 |=> (flag_q & $past(set_ev)) == $past(set_ev))
        else $error("flag not set"); // RULE13
    shadow_rsv_a: assert property (win_ok && (!vector_config_bit || ss_fld[3]) |=> irq_shadow_set == 3'd0)
        else $error("bad shadow set"); // RULE7
    single_sh_a: assert property (win_ok && !vector_config_bit |=> irq_shadow_en == $past(shadow_q[0]))
        else $error("single shadow wrong"); // RULE9
    enable_gate_a: assert property (irq_req |-> (($past(en_q) >> irq_num[4:0]) & 32'd1) == 32'd1)
        else $error("disabled request"); // RULE15
    last_serviced_request_a: assert property (irq_ack && irq_req |=> last_srv_q == $past(irq_num))
        else $error("serviced id wrong"); // RULE11
    hold_a: assert property (hold_all && win_ok |-> !qual[win_idx])
        else $error("held request leaked"); // RULE17
endmodule : vectored_interrupt_controller

// ### verilog/vic_defines.svh
// Offsets, field positions, masks and reset values of the interrupt controller.
// Assumes inclusion by bare name from the design file.
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL   8'h00
`define OFS_SHADOW 8'h04
`define OFS_STAT   8'h08
`define OFS_RELOAD 8'h0C
`define OFS_FLAG   8'h10
`define OFS_EN     8'h14
`define OFS_NMI    8'h18
`define OFS_PRIO   8'h20
// ****************************************
// Fields and masks
// ****************************************
`define KEY_LSB    24
`define KEY_VALUE  8'h4E
`define VECTOR_CONFIG_BIT_BIT   12
`define TPC_LSB    8
`define CTRL_MASK  32'hFF00_171F
`define SHADOW_MASK 32'hFFFF_FFF1
`define PRIO_MASK  32'h1F1F_1F1F
`define RST_WORD   32'h0000_0000
`define RESP_OKAY  2'b00
`define RESP_SLVERR 2'b10
`endif

// ### verilog/vic_pkg.sv
// Types shared by the interrupt controller.
// Assumes the defines header carries every number.
package vic_pkg;
    // One-hot proximity timer states
    typedef enum logic [1:0] {
        PROX_IDLE = 2'b01,
        PROX_RUN  = 2'b10
    } prox_state_e;
endpackage : vic_pkg

// ### bench/core_model.sv
// Core model: acknowledges a standing request after a delay.
// Assumes the controller holds irq_req until the flag is cleared.
`timescale 1ns/1ps
module core_model #(
    parameter int ACK_LAT = 3
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Controller side
    input  wire logic irq_req,
    input  wire logic ack_en,
    output logic      irq_ack
);
    // ****************
    // Acknowledge
    // ****************
    int cnt_q;
    // Holding ack_en low gives a core that never acknowledges
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !irq_req || !ack_en)
        begin
            cnt_q   <= 0;
            irq_ack <= 1'b0;
        end
        else
        begin
            cnt_q   <= (cnt_q == ACK_LAT) ? 0 : cnt_q + 1;
            irq_ack <= (cnt_q == ACK_LAT); // One-cycle pulse
        end
    end
endmodule : core_model

// ### bench/tb_vectored_interrupt_controller.sv
// Bench: registers, routing, shadow sets, edges, proximity timer.
// Assumes the defines header and the core model.
`timescale 1ns/1ps
`include "vic_defines.svh"
`define CHK(g, e) chk_v(32'(g), 32'(e))
module tb_vectored_interrupt_controller;
    // ****************
    // Signals
    // ****************
    typedef struct {logic [31:0] ctl, rl, pw; int lo, hi;} prox_s;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack_en;
    logic        awready, wready, bvalid, arready, rvalid, irq_ack, irq_req;
    logic        irq_shadow_en, nmi_pulse;
    logic [7:0]  awaddr, araddr, irq_num;
    logic [31:0] wdata, rdata, src_req, rd;
    logic [3:0]  wstrb;
    logic [4:0]  ext_irq;
    logic [1:0]  bresp, rresp, b_resp, r_resp;
    logic [2:0]  irq_level, irq_shadow_set;
    int          n_errors, cmp_count, cyc, nmi_cnt, n;
    logic [7:0]  ofs [6] = '{`OFS_CTRL, `OFS_SHADOW, `OFS_STAT, `OFS_RELOAD, `OFS_FLAG, `OFS_EN};
    logic [3:0]  ss_code [5] = '{4'h0, 4'h5, 4'h7, 4'h8, 4'hF};
    prox_s       prox [5] = '{'{32'h300, 3, 32'h0C00, 4, 8}, '{32'h300, 20, 32'h0C00, 21, 25},
                              '{32'h300, 20, 32'h1000, 1, 3}, '{32'h0, 20, 32'h0C00, 1, 3},
                              '{32'h100, 20, 32'h0400, 21, 25}};

    vectored_interrupt_controller u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .src_req(src_req), .ext_irq(ext_irq), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_num(irq_num), .irq_level(irq_level), .irq_shadow_en(irq_shadow_en),
        .irq_shadow_set(irq_shadow_set), .nmi_pulse(nmi_pulse));
    core_model #(.ACK_LAT(3)) u_core (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
        .ack_en(ack_en), .irq_ack(irq_ack));

    // ****************
    // Clock, watchdog, monitors
    // ****************
    always #2 aclk = ~aclk;
    // Bound well above the longest sequence
    always @(posedge aclk)
    begin
        cyc++;
        nmi_cnt += (nmi_pulse === 1'b1);
        if (cyc == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    // ****************
    // Tasks
    // ****************
    task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_v
    // Address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            b_resp = bresp;
        end while (!bvalid);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
        araddr  <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            rd = rdata;
            r_resp = rresp;
        end while (!rvalid);
        `CHK(rd, e);
    endtask : axi_rd
    task automatic pulse(input logic [31:0] m);
        @(posedge aclk);
        src_req <= m;
        @(posedge aclk);
        src_req <= '0;
    endtask : pulse
    task automatic wait_irq();
        n = 0;
        while (irq_req !== 1'b1 && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        // A wait that runs out is a mismatch
        if (n == 100) n_errors++;
    endtask : wait_irq
    task automatic report_and_stop();
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; arvalid = 0; bready = 1; rready = 1;
        ack_en = 1; awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF; src_req = 0; ext_irq = 0;
        n_errors = 0; cmp_count = 0; cyc = 0; nmi_cnt = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        foreach (ofs[i]) axi_rd(ofs[i], `RST_WORD);
        axi_wr(`OFS_CTRL, 32'hFFFF_FFFF);
        axi_rd(`OFS_CTRL, `CTRL_MASK);
        axi_wr(`OFS_SHADOW, 32'hFFFF_FFFF);
        axi_rd(`OFS_SHADOW, `SHADOW_MASK);
        axi_wr(`OFS_STAT, 32'hFFFF_FFFF);
        axi_rd(`OFS_STAT, `RST_WORD);
        `CHK(nmi_cnt, 0);
        axi_wr(8'h1C, 32'h1);
        `CHK(b_resp, `RESP_SLVERR);
        axi_rd(8'h1C, 32'h0);
        `CHK(r_resp, `RESP_SLVERR);
        axi_wr(`OFS_CTRL, {`KEY_VALUE, 24'h0});
        axi_rd(`OFS_NMI, 32'h1);
        `CHK(nmi_cnt, 1);
        axi_wr(`OFS_NMI, 32'h1);
        axi_rd(`OFS_NMI, 32'h0);
        axi_wr(`OFS_CTRL, 32'h0);
        // One source end to end, then masked
        axi_wr(`OFS_PRIO + 8'h04, 32'h0000_0C00);
        axi_wr(`OFS_EN, 32'h0000_1F20);
        pulse(32'h20);
        wait_irq();
        `CHK({irq_num, 5'h0, irq_level}, {8'd5, 5'h0, 3'd3});
        axi_rd(`OFS_FLAG, 32'h20);
        repeat (6) @(posedge aclk);
        axi_rd(`OFS_STAT, 32'h0305);
        axi_wr(`OFS_EN, 32'h0000_1F00);
        repeat (2) @(posedge aclk);
        `CHK(irq_req, 0);
        axi_wr(`OFS_FLAG, 32'h0);
        axi_rd(`OFS_FLAG, 32'h0);
        // Ties: subpriority, then number; zero priority and mask lose
        axi_wr(`OFS_PRIO + 8'h08, 32'h0308_0F0E);
        axi_wr(`OFS_PRIO + 8'h0C, 32'h0000_1C0E);
        pulse(32'h0000_3F00);
        wait_irq();
        `CHK(irq_num, 9);
        axi_wr(`OFS_FLAG, 32'h0000_3D00);
        repeat (2) @(posedge aclk);
        `CHK(irq_num, 8);
        axi_wr(`OFS_FLAG, 32'h0000_2800);
        repeat (2) @(posedge aclk);
        `CHK(irq_req, 0);
        axi_wr(`OFS_FLAG, 32'h0);
        // Shadow sets for level 3, level 2 holds a decoy
        axi_wr(`OFS_EN, 32'h20);
        pulse(32'h20);
        wait_irq();
        axi_wr(`OFS_CTRL, 32'h0000_1000);
        foreach (ss_code[i])
        begin
            axi_wr(`OFS_SHADOW, {16'h0, ss_code[i], 12'h600});
            repeat (2) @(posedge aclk);
            `CHK({irq_shadow_en, irq_shadow_set}, {1'b1, ss_code[i][3] ? 3'd0 : ss_code[i][2:0]});
        end
        axi_wr(`OFS_SHADOW, 32'h0000_7001);
        axi_wr(`OFS_CTRL, 32'h0);
        repeat (2) @(posedge aclk);
        `CHK({irq_shadow_en, irq_shadow_set}, 4'h8);
        axi_wr(`OFS_SHADOW, 32'h0000_7000);
        repeat (2) @(posedge aclk);
        `CHK(irq_shadow_en, 0);
        axi_wr(`OFS_FLAG, 32'h0);
        // External edges: rising on 0,2,4 and falling on 1,3
        axi_wr(`OFS_CTRL, 32'h0000_0015);
        ext_irq <= 5'h1F;
        repeat (4) @(posedge aclk);
        axi_rd(`OFS_FLAG, 32'h15);
        axi_wr(`OFS_FLAG, 32'h0);
        ext_irq <= 5'h00;
        repeat (4) @(posedge aclk);
        axi_rd(`OFS_FLAG, 32'h0A);
        axi_wr(`OFS_FLAG, 32'h0);
        // Proximity hold against threshold and reload
        foreach (prox[i])
        begin
            axi_wr(`OFS_CTRL, prox[i].ctl);
            axi_wr(`OFS_RELOAD, prox[i].rl);
            axi_wr(`OFS_PRIO + 8'h04, prox[i].pw);
            pulse(32'h20);
            wait_irq();
            `CHK(n >= prox[i].lo && n <= prox[i].hi, 1);
            axi_wr(`OFS_FLAG, 32'h0);
            repeat (3) @(posedge aclk);
        end
        report_and_stop();
    end
endmodule : tb_vectored_interrupt_controller
